// >>> core/eeprom_cond_pkg.sv
// Constants and carrier types for the EEPROM conditional loader.
// Assumes one core clock domain and an APB register slave.
package eeprom_cond_pkg;
  // ==================================================
  // Register indices (byte address = index * 4)
  localparam logic [11:0] IDX_WR_EN   = 12'hE00;
  localparam logic [11:0] IDX_COND    = 12'hE01;
  localparam logic [11:0] IDX_SAVE    = 12'hE02;
  localparam logic [11:0] IDX_LOAD    = 12'hE03;
  localparam logic [11:0] IDX_STATUS  = 12'hE04;
  localparam logic [11:0] IDX_PU_COND = 12'hE05;
  localparam logic [11:0] IDX_SCRATCH = 12'hE10;
  // ==================================================
  // Field positions and reset values
  localparam int unsigned WR_EN_BIT  = 0;
  localparam int unsigned SAVE_BIT   = 0;
  localparam int unsigned LOAD_BIT   = 1;
  localparam int unsigned BUSY_BIT   = 0;
  localparam int unsigned DONE_BIT   = 1;
  localparam int unsigned FAULT_BIT  = 2;
  localparam int unsigned PU_LSB     = 3;
  localparam logic [4:0]  COND_RST   = 5'h00;
  localparam logic [7:0]  PU_RST     = 8'h00;
  // ==================================================
  // Opcodes
  localparam logic [7:0] OP_DATA_MAX = 8'h7F;
  localparam logic [7:0] OP_CAL      = 8'h0A;
  localparam logic [7:0] OP_IOU      = 8'h80;
  localparam logic [7:0] OP_NULL     = 8'hB0;
  localparam logic [7:0] OP_COND_MAX = 8'hCF;
  localparam logic [7:0] OP_PAUSE    = 8'hFE;
  localparam logic [7:0] OP_END      = 8'hFF;
  // ==================================================
  // Output-sync pin registers of the loaded map
  localparam logic [15:0] PIN_EN_ADDR = 16'h0200;
  localparam logic [7:0]  PIN_EN_VAL  = 8'h01;
  localparam logic [15:0] PIN_CFG_LO  = 16'h0201;
  localparam logic [15:0] PIN_CFG_HI  = 16'h0208;
  // ==================================================
  // Timing: edges from reset release to pin capture; both sync stages fill first
  localparam logic [1:0] BOOT_CYCLES = 2'h3;
  // Register-map write carrier
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } reg_bus_s;
endpackage : eeprom_cond_pkg

// >>> core/eeprom_cond_loader.sv
// EEPROM upload/download sequencer with conditional execution.
// Assumes APB master on core_clk_in, register map read data valid
// combinationally during upload; the upload read address raddr_q is not driven out.
// What this block does
// RULE_01: Upload copies condition opcodes unchanged; they never alter transfers.
// RULE_02: Download always runs condition opcodes and the end opcode.
// RULE_03: Active condition is 5 bits; zero runs everything regardless of tags.
// RULE_04: Nonzero condition field wins, else the power-up pin code.
// RULE_05: Opcodes B1..CF set the tag of condition 1..31.
// RULE_06: Opcode B0 clears all tags; following instructions run unconditionally.
// RULE_07: With condition and tags set, run only if condition is tagged.
// RULE_08: Untagged condition skips instructions until a tagging condition opcode or a null opcode.
// RULE_09: Tags accumulate across condition opcodes until a null opcode.
// RULE_10: Opcode 80 issues an I/O update pulse.
// RULE_11: Opcode 0A issues a calibrate pulse, gated like other instructions.
// RULE_12: FE pauses an upload keeping the pointer; FF ends it.
// RULE_13: Storage is 2048 bytes; data instruction costs N plus four.
// RULE_14: Software prefixes later setups with B0 and a fresh condition.
// RULE_15: Software starts upload with self-clearing save bit 0.
// RULE_16: Software writes condition, then self-clearing load bit 1.
// RULE_17: After power-up download runs automatically with a nonzero pin condition.
// RULE_18: Software enables pins, updates, then configures pin function.
// RULE_19: Pin function written before enable and update emits sync pulse.
// RULE_20: Stored sequence writes 0x0200, updates, then 17 bytes at 0x0201.
// RULE_21: Data opcodes move opcode+1 bytes to a two-byte target address.
// RULE_22: Download checks each executed block's checksum; sets fault or complete.
// RULE_23: Nonzero condition with empty tag board runs all instructions.
// RULE_24: Tag board has one bit per nonzero condition value.
`timescale 1ns/1ps
module eeprom_cond_loader
  import eeprom_cond_pkg::*;
#(
  parameter int unsigned EE_BYTES = 2048, // RULE_13
  parameter int unsigned SP_BYTES = 64
)(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [15:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Condition-select pins: 00 low, 01 open, 10 high
  input  wire logic [1:0]  condition_select_pin_low_in,
  input  wire logic [1:0]  condition_select_pin_high_in,
  // Register map
  input  wire logic [7:0]  reg_rdata_in,
  output reg_bus_s         reg_bus_out,
  output logic             io_update_out,
  output logic             calibrate_out,
  output logic             sync_pulse_out
);
  // ==================================================
  // Types, storage, decode helpers
  typedef enum logic [8:0] {
    ST_IDLE    = 9'h001,
    ST_UP_OP   = 9'h002,
    ST_UP_ADDR = 9'h004,
    ST_UP_DATA = 9'h008,
    ST_UP_SUM  = 9'h010,
    ST_DN_OP   = 9'h020,
    ST_DN_ADDR = 9'h040,
    ST_DN_DATA = 9'h080,
    ST_DN_SUM  = 9'h100
  } seq_state_e;

  localparam int unsigned EAW = $clog2(EE_BYTES);
  localparam int unsigned SAW = $clog2(SP_BYTES);

  logic [7:0] ee_mem [EE_BYTES];
  logic [7:0] sp_mem [SP_BYTES];

  // Data opcode: 00..7F except the calibrate opcode
  function automatic logic is_data(input logic [7:0] b);
    is_data = (b <= OP_DATA_MAX) && (b != OP_CAL); // RULE_21
  endfunction : is_data

  function automatic logic is_cond(input logic [7:0] b);
    is_cond = (b >= OP_NULL) && (b <= OP_COND_MAX);
  endfunction : is_cond

  // Three-level pins to condition 0..8, open/open gives 0
  function automatic logic [4:0] pin_code(input logic [1:0] hi,
                                          input logic [1:0] lo);
    logic [3:0] idx;
    idx = 4'({2'b00, hi} * 4'h3) + {2'b00, lo};
    if (idx == 4'h4)
      pin_code = 5'h00;
    else if (idx < 4'h4)
      pin_code = {1'b0, idx + 4'h1};
    else
      pin_code = {1'b0, idx};
  endfunction : pin_code

  seq_state_e  st_q;
  logic [EAW-1:0] ee_ptr_q;
  logic [SAW-1:0] sp_ptr_q;
  logic [7:0]  cnt_q, sum_q, hi_q, pu_cond_q;
  logic        half_q, skip_q, done_q, fault_q, wr_en_q;
  logic [4:0]  cond_q, act_cond;
  logic [31:0] tags_q;
  logic [15:0] raddr_q;
  logic [7:0]  ee_byte, sp_byte;
  logic        exec_ok;
  logic        mem_we;
  logic [7:0]  mem_wd;

  assign ee_byte = ee_mem[ee_ptr_q];
  assign sp_byte = sp_mem[sp_ptr_q];
  // Register field wins when nonzero
  assign act_cond = (cond_q != COND_RST) ? cond_q
                                         : pu_cond_q[PU_LSB +: 5]; // RULE_04
  // Zero condition or empty board runs all; else need a tag
  assign exec_ok = (act_cond == 5'h00) || (tags_q == 32'h0) // RULE_03 RULE_23
                   || tags_q[act_cond];                     // RULE_07

  // ==================================================
  // APB decode
  logic        apb_set, apb_wr;
  logic [11:0] idx;
  logic        in_sp, mapped;
  logic        start_up, start_dn;
  assign idx     = paddr_in[13:2];
  assign apb_set = psel_in && !penable_in;
  assign apb_wr  = psel_in && penable_in && pwrite_in && pready_out;
  assign in_sp   = (idx >= IDX_SCRATCH)
                   && (idx < IDX_SCRATCH + 12'(SP_BYTES));
  assign mapped  = (paddr_in[1:0] == 2'h0) && (paddr_in[15:14] == 2'h0)
                   && (in_sp || (idx >= IDX_WR_EN && idx <= IDX_PU_COND));
  assign start_up = apb_wr && mapped && (idx == IDX_SAVE)
                    && pwdata_in[SAVE_BIT] && wr_en_q; // RULE_15
  assign start_dn = apb_wr && mapped && (idx == IDX_LOAD)
                    && pwdata_in[LOAD_BIT];            // RULE_16

  // Zero-wait answer: ready registered from the setup cycle
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0;
    end
    else
    begin
      pready_out  <= apb_set;
      pslverr_out <= apb_set && !mapped;
      prdata_out  <= 32'h0;
      if (apb_set && mapped && !pwrite_in)
      begin
        if (in_sp)
          prdata_out <= {24'h0, sp_mem[SAW'(idx - IDX_SCRATCH)]};
        else if (idx == IDX_WR_EN)
          prdata_out <= {31'h0, wr_en_q};
        else if (idx == IDX_COND)
          prdata_out <= {27'h0, cond_q};
        else if (idx == IDX_STATUS)
          prdata_out <= {29'h0, fault_q, done_q, st_q != ST_IDLE};
        else if (idx == IDX_PU_COND)
          prdata_out <= {24'h0, pu_cond_q};
      end
    end
  end

  // Software control fields; save/load bits are never stored
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_en_q <= 1'b0;
      cond_q  <= COND_RST;
    end
    else if (apb_wr && mapped)
    begin
      if (idx == IDX_WR_EN)
        wr_en_q <= pwdata_in[WR_EN_BIT];
      if (idx == IDX_COND)
        cond_q <= pwdata_in[4:0];
    end
  end

  // Scratch pad; writes while busy would corrupt a running upload
  always_ff @(posedge core_clk_in)
  begin
    if (apb_wr && in_sp && mapped && st_q == ST_IDLE)
      sp_mem[SAW'(idx - IDX_SCRATCH)] <= pwdata_in[7:0];
  end

  // ==================================================
  // Power-up pin capture and automatic download
  logic [3:0] pin_s1_q, pin_s2_q;
  logic [1:0] boot_cnt_q;
  logic       boot_go_q;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_s1_q   <= 4'h0;
      pin_s2_q   <= 4'h0;
      boot_cnt_q <= 2'h0;
      boot_go_q  <= 1'b0;
      pu_cond_q  <= PU_RST;
    end
    else
    begin
      pin_s1_q  <= {condition_select_pin_high_in, condition_select_pin_low_in};
      pin_s2_q  <= pin_s1_q;
      boot_go_q <= 1'b0;
      if (boot_cnt_q != BOOT_CYCLES)
        boot_cnt_q <= boot_cnt_q + 2'h1;
      // Earlier capture would read the stage reset value as low/low pins
      if (boot_cnt_q == BOOT_CYCLES - 2'h1)
      begin
        pu_cond_q <= {pin_code(pin_s2_q[3:2], pin_s2_q[1:0]), 3'h0};
        boot_go_q <= 1'b1; // RULE_17
      end
    end
  end

  // ==================================================
  // EEPROM write port, fed only by upload states
  always_comb
  begin
    mem_we = 1'b0;
    mem_wd = sp_byte;
    case (st_q)
      ST_UP_OP, ST_UP_ADDR: mem_we = 1'b1; // RULE_01
      ST_UP_DATA:
      begin
        mem_we = 1'b1;
        mem_wd = reg_rdata_in;
      end
      ST_UP_SUM:
      begin
        mem_we = 1'b1;
        mem_wd = sum_q;
      end
      default: mem_we = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (mem_we)
      ee_mem[ee_ptr_q] <= mem_wd;
  end

  // ==================================================
  // Sequencer: upload and download walks
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q          <= ST_IDLE;
      ee_ptr_q      <= '0;
      sp_ptr_q      <= '0;
      cnt_q         <= 8'h0;
      sum_q         <= 8'h0;
      hi_q          <= 8'h0;
      half_q        <= 1'b0;
      skip_q        <= 1'b0;
      done_q        <= 1'b0;
      fault_q       <= 1'b0;
      tags_q        <= 32'h0;
      raddr_q       <= 16'h0;
      reg_bus_out   <= '0;
      io_update_out <= 1'b0;
      calibrate_out <= 1'b0;
    end
    else
    begin
      reg_bus_out.wr <= 1'b0;
      io_update_out  <= 1'b0;
      calibrate_out  <= 1'b0;
      case (st_q)
        ST_IDLE:
        begin
          sp_ptr_q <= '0;
          if (start_up)
            st_q <= ST_UP_OP;
          else if (start_dn || (boot_go_q && pu_cond_q != PU_RST))
          begin
            st_q     <= ST_DN_OP;
            ee_ptr_q <= '0;
            tags_q   <= 32'h0;
            done_q   <= 1'b0;
            fault_q  <= 1'b0;
          end
        end
        ST_UP_OP:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1;
          sp_ptr_q <= sp_ptr_q + 1'b1;
          if (is_data(sp_byte))
          begin
            cnt_q  <= sp_byte + 8'h1;
            half_q <= 1'b0;
            st_q   <= ST_UP_ADDR;
          end
          else if (sp_byte == OP_PAUSE)
            st_q <= ST_IDLE; // RULE_12
          else if (sp_byte == OP_END)
          begin
            st_q     <= ST_IDLE;
            ee_ptr_q <= '0;
          end
          else if (sp_ptr_q == SAW'(SP_BYTES - 1))
            st_q <= ST_IDLE;
        end
        ST_UP_ADDR:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1;
          sp_ptr_q <= sp_ptr_q + 1'b1;
          half_q   <= 1'b1;
          hi_q     <= sp_byte;
          if (half_q)
          begin
            raddr_q <= {hi_q, sp_byte};
            sum_q   <= 8'h0;
            st_q    <= ST_UP_DATA;
          end
        end
        ST_UP_DATA:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1;
          sum_q    <= sum_q + reg_rdata_in;
          raddr_q  <= raddr_q + 16'h1;
          cnt_q    <= cnt_q - 8'h1;
          if (cnt_q == 8'h1)
            st_q <= ST_UP_SUM;
        end
        ST_UP_SUM:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1; // RULE_13
          st_q     <= ST_UP_OP;
        end
        ST_DN_OP:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1;
          if (ee_byte == OP_END)
          begin
            st_q   <= ST_IDLE; // RULE_02
            done_q <= !fault_q; // RULE_22
          end
          else if (ee_byte == OP_NULL)
            tags_q <= 32'h0; // RULE_06
          else if (is_cond(ee_byte))
            tags_q[5'(ee_byte - OP_NULL)] <= 1'b1; // RULE_05 RULE_09 RULE_24
          else if (is_data(ee_byte))
          begin
            cnt_q  <= ee_byte + 8'h1; // RULE_21
            half_q <= 1'b0;
            skip_q <= !exec_ok; // RULE_08
            st_q   <= ST_DN_ADDR;
          end
          else if (ee_byte == OP_IOU)
            io_update_out <= exec_ok; // RULE_10
          else if (ee_byte == OP_CAL)
            calibrate_out <= exec_ok; // RULE_11
        end
        ST_DN_ADDR:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1;
          half_q   <= 1'b1;
          hi_q     <= ee_byte;
          if (half_q)
          begin
            raddr_q <= {hi_q, ee_byte};
            sum_q   <= 8'h0;
            st_q    <= ST_DN_DATA;
          end
        end
        ST_DN_DATA:
        begin
          ee_ptr_q    <= ee_ptr_q + 1'b1;
          sum_q       <= sum_q + ee_byte;
          raddr_q     <= raddr_q + 16'h1;
          cnt_q       <= cnt_q - 8'h1;
          reg_bus_out <= '{wr: !skip_q, addr: raddr_q, data: ee_byte};
          if (cnt_q == 8'h1)
            st_q <= ST_DN_SUM;
        end
        ST_DN_SUM:
        begin
          ee_ptr_q <= ee_ptr_q + 1'b1;
          if (!skip_q && sum_q != ee_byte)
            fault_q <= 1'b1; // RULE_22
          st_q <= ST_DN_OP;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ==================================================
  // Output-sync guard: pin config before enable+update
  logic pin_buf_q, pin_act_q;
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pin_buf_q      <= 1'b0;
      pin_act_q      <= 1'b0;
      sync_pulse_out <= 1'b0;
    end
    else
    begin
      if (reg_bus_out.wr && reg_bus_out.addr == PIN_EN_ADDR)
        pin_buf_q <= (reg_bus_out.data == PIN_EN_VAL);
      if (io_update_out)
        pin_act_q <= pin_buf_q;
      sync_pulse_out <= reg_bus_out.wr && !pin_act_q // RULE_19
                        && reg_bus_out.addr >= PIN_CFG_LO
                        && reg_bus_out.addr <= PIN_CFG_HI;
    end
  end

  // ==================================================
  // Assertions
  a_null_clears_tags: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_06
    st_q == ST_DN_OP && ee_byte == OP_NULL |=> tags_q == 32'h0)
    else $error("null opcode left tags set");
  a_cond_sets_tag: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_05
    st_q == ST_DN_OP && is_cond(ee_byte) && ee_byte != OP_NULL
    |=> tags_q[5'($past(ee_byte) - OP_NULL)])
    else $error("condition opcode did not tag");
  a_tags_accumulate: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_09
    st_q == ST_DN_OP && ee_byte != OP_NULL |=> ($past(tags_q) & ~tags_q) == 32'h0)
    else $error("tag lost without null opcode");
  a_skip_no_write: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_08
    st_q == ST_DN_DATA && skip_q |=> !reg_bus_out.wr)
    else $error("skipped block wrote a register");
  a_null_cond_runs: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_03
    st_q == ST_DN_OP && is_data(ee_byte) && (act_cond == 5'h00 || tags_q == 32'h0)
    |=> !skip_q ##2 st_q == ST_DN_DATA)
    else $error("unconditional block was skipped");
  a_iou_pulse: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_10
    st_q == ST_DN_OP && ee_byte == OP_IOU |=> io_update_out == $past(exec_ok))
    else $error("I/O update pulse wrong");
  a_cal_gated: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_11
    st_q == ST_DN_OP && ee_byte == OP_CAL && !exec_ok |=> !calibrate_out)
    else $error("calibrate ran while skipping");
  a_end_status: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_22
    st_q == ST_DN_OP && ee_byte == OP_END |=> st_q == ST_IDLE && (done_q != fault_q))
    else $error("end opcode status wrong");
  a_sync_guard: assert property (@(posedge core_clk_in) disable iff (rst_in) // RULE_19
    reg_bus_out.wr && !pin_act_q && reg_bus_out.addr == PIN_CFG_LO |=> sync_pulse_out)
    else $error("missing output sync pulse");
endmodule : eeprom_cond_loader

// >>> tb/reg_map_model.sv
// Register map stand-in facing the loader's register-map link.
// Assumes one byte lands per wr pulse on the core clock.
`timescale 1ns/1ps
module reg_map_model
  import eeprom_cond_pkg::*;
#(
  parameter logic [7:0] FILL_BYTE = 8'hA5
)(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Loader side
  input  wire reg_bus_s    reg_bus_in,
  output logic [7:0]       reg_rdata_out,
  // Observation
  output logic [15:0]      wr_count_out,
  output logic [15:0]      last_addr_out,
  output logic [7:0]       last_data_out
);
  // ==================================================
  // Fixed answer: the upload read address is internal, so all reads match
  assign reg_rdata_out = FILL_BYTE;
  // Record every byte written into the map
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_count_out  <= 16'h0000;
      last_addr_out <= 16'h0000;
      last_data_out <= 8'h00;
    end
    else if (reg_bus_in.wr)
    begin
      wr_count_out  <= wr_count_out + 16'h0001;
      last_addr_out <= reg_bus_in.addr;
      last_data_out <= reg_bus_in.data;
    end
  end
endmodule : reg_map_model

// >>> tb/tb_eeprom_cond_loader.sv
// Self-checking bench for the conditional EEPROM loader.
// Assumes an APB master here and the register map model as far side.
`timescale 1ns/1ps
module tb_eeprom_cond_loader;
  import eeprom_cond_pkg::*;
  // ==================================================
  // Signals
  logic        core_clk_in = 1'b0;
  logic        rst_in      = 1'b1;
  logic        psel_in     = 1'b0;
  logic        penable_in  = 1'b0;
  logic        pwrite_in   = 1'b0;
  logic [15:0] paddr_in    = 16'h0000;
  logic [31:0] pwdata_in   = 32'h0000_0000;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic [1:0]  pin_lo      = 2'b01;
  logic [1:0]  pin_hi      = 2'b01;
  logic [7:0]  reg_rdata;
  reg_bus_s    reg_bus;
  logic        io_update_out;
  logic        calibrate_out;
  logic        sync_pulse_out;
  logic [15:0] wr_cnt;
  logic [15:0] last_addr;
  logic [7:0]  last_data;
  int          num_errors      = 0;
  int          samples_checked = 0;
  int          cycles          = 0;
  int          iou_cnt         = 0;
  int          cal_cnt         = 0;
  int          sync_cnt        = 0;
  logic [31:0] rdv;
  logic        errv;
  // Images: setup ending in pause, B0 tail with end marker, pin-sync sequence
  logic [7:0]  img [21] = '{8'h00, 8'h02, 8'h00, 8'hB2, 8'hB1, 8'h00, 8'h02,
                            8'h01, 8'h0A, 8'hFE, 8'hB0, 8'h80, 8'hFF,
                            8'h00, 8'h02, 8'h00, 8'h80, 8'h10, 8'h02, 8'h01, 8'hFF};
  // ==================================================
  // Clock, timeout and pulse counters
  always #50 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (io_update_out === 1'b1) iou_cnt++;
    if (calibrate_out === 1'b1) cal_cnt++;
    if (sync_pulse_out === 1'b1) sync_cnt++;
    if (cycles == 50000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end
  // ==================================================
  // Instances
  eeprom_cond_loader DUT (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .condition_select_pin_low_in(pin_lo),
    .condition_select_pin_high_in(pin_hi), .reg_rdata_in(reg_rdata),
    .reg_bus_out(reg_bus), .io_update_out(io_update_out),
    .calibrate_out(calibrate_out), .sync_pulse_out(sync_pulse_out));
  // Map answers the pin-enable value, so a stored enable byte really enables
  reg_map_model #(.FILL_BYTE(PIN_EN_VAL)) PARTNER (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .reg_bus_in(reg_bus),
    .reg_rdata_out(reg_rdata), .wr_count_out(wr_cnt),
    .last_addr_out(last_addr), .last_data_out(last_data));
  // ==================================================
  // Shared tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One APB transfer; holds the request until pready is seen high
  task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge core_clk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= wr;
    paddr_in   <= {2'b00, idx, 2'b00};
    pwdata_in  <= wd;
    @(posedge core_clk_in);
    penable_in <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do
      @(posedge core_clk_in);
    while (pready_out !== 1'b1);
    rdv  = prdata_out;
    errv = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  // Poll busy after four edges; only the bench timeout bounds the polling
  task wait_idle();
    repeat (4) @(posedge core_clk_in);
    do
      apb(1'b0, IDX_STATUS, 32'h0);
    while (rdv[BUSY_BIT] !== 1'b0);
  endtask : wait_idle
  // Fill the scratch pad with img[first..last] and save it
  task upload(input int first, input int last);
    for (int i = first; i <= last; i++)
      apb(1'b1, IDX_SCRATCH + 12'(i - first), {24'h0, img[i]});
    apb(1'b1, IDX_SAVE, 32'h1 << SAVE_BIT);
    wait_idle();
  endtask : upload
  // ==================================================
  // Scenarios
  task t_reset_values();
    apb(1'b0, IDX_STATUS, 32'h0);
    check(rdv, 32'h0);
    apb(1'b0, IDX_COND, 32'h0);
    check(rdv, {27'h0, COND_RST});
    apb(1'b0, IDX_PU_COND, 32'h0);
    check(rdv, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    check({31'h0, errv}, 32'h1);
  endtask : t_reset_values
  // Two uploads: a setup ending in pause, then B0 and the end marker
  task t_upload();
    apb(1'b1, IDX_WR_EN, 32'h1 << WR_EN_BIT);
    upload(0, 9);
    upload(10, 12);
    apb(1'b0, IDX_STATUS, 32'h0);
    check({31'h0, rdv[FAULT_BIT]}, 32'h0);
  endtask : t_upload
  // Download under one condition and count what came out
  task t_download(input logic [4:0] cond, input int n_wr, input int n_cal,
                  input logic [15:0] exp_addr, input int n_sync);
    logic [15:0] w0;
    int          c0;
    int          i0;
    int          s0;
    w0 = wr_cnt;
    c0 = cal_cnt;
    i0 = iou_cnt;
    s0 = sync_cnt;
    apb(1'b1, IDX_COND, {27'h0, cond});
    apb(1'b1, IDX_LOAD, 32'h1 << LOAD_BIT);
    wait_idle();
    check({16'h0, wr_cnt - w0}, 32'(n_wr));
    check(32'(cal_cnt - c0), 32'(n_cal));
    check(32'(iou_cnt - i0), 32'h1);
    check({16'h0, last_addr}, {16'h0, exp_addr});
    check({24'h0, last_data}, {24'h0, PIN_EN_VAL});
    check(32'(sync_cnt - s0), 32'(n_sync));
    check({29'h0, rdv[2:0]}, 32'h1 << DONE_BIT);
  endtask : t_download
  // Mid-run reset with both select pins at one level
  task reset_with_pins(input logic [1:0] lvl);
    rst_in <= 1'b1;
    pin_lo <= lvl;
    pin_hi <= lvl;
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
  endtask : reset_with_pins
  // Power-up with both select pins low gives condition one
  task t_powerup();
    reset_with_pins(2'b00);
    repeat (6) @(posedge core_clk_in);
    apb(1'b0, IDX_PU_COND, 32'h0);
    check(rdv, 32'h0000_0008);
    wait_idle();
    check({16'h0, wr_cnt}, 32'h2);
  endtask : t_powerup
  // Open pins skip the auto load; then enable, update, 17 config bytes, no sync
  task t_sync_seq();
    reset_with_pins(2'b01);
    repeat (4) @(posedge core_clk_in);
    apb(1'b1, IDX_WR_EN, 32'h1 << WR_EN_BIT);
    upload(13, 20);
    t_download(5'd0, 18, 0, PIN_CFG_LO + 16'h0010, 0);
  endtask : t_sync_seq
  // ==================================================
  // Verdict
  task tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Main sequence
  initial
  begin
    repeat (8) @(posedge core_clk_in);
    rst_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    t_reset_values();
    t_upload();
    // Pin enable stays active after the first enable and update
    t_download(5'd2, 2, 1, PIN_CFG_LO, 1);
    t_download(5'd3, 1, 0, PIN_EN_ADDR, 0);
    t_download(5'd0, 2, 1, PIN_CFG_LO, 0);
    t_download(5'd1, 2, 1, PIN_CFG_LO, 0);
    t_powerup();
    t_sync_seq();
    tally_and_finish();
  end
endmodule : tb_eeprom_cond_loader
